// file: rtl/adcw_readout.sv
// Overview of operation
// [R01] External variant converts only on bit clock edges, its master clock.
// [R02] Data line driven low when word ready and select low; released when select high.
// [R03] External variant: ready low appears on a bit clock rising edge.
// [R04] Shift starts after the next falling edge; first bit 1.5 cycles; 24 cycles total.
// [R05] Next bit changes on falling edges; host samples on rising edges.
// [R06] After the full word the data line stays high until a new word.
// [R07] Select high at conversion end holds the word until select goes low; the code keeps converting and the next result replaces it.
// [R08] A conversion finishing during shifting is discarded; register unchanged.
// [R09] Host skips a conversion by holding select high for the whole cycle.
// [R10] Select rising mid-read abandons the word; next result replaces it.
// [R11] Internal variant converts from power-up; host gives 24 clocks per word.
// [R12] Internal variant: unread word raises line 17 oscillator cycles early.
// [R13] Internal variant: unread word overwritten by next result.
// [R14] Word is 24 bits: bits 23, 20 zero; 22 overrange; 21 oscillation.
// [R15] 16-bit: header, four zeros, 16 data; 20-bit: header, 20 data, MSB first.
// [R16] Overrange flag set beyond full scale, cleared on next in-range word.
// [R17] Oscillation flag set on detect, cleared four words after stable.
// [R18] Two's complement data saturating at the full-scale codes of its width.
// [R19] One conversion per 612 master clock periods.
// [R20] Results unsettled until four conversion cycles after power-up or wake.
// [R21] Bit clock high for 200 us enters sleep; host keeps it low when idle.
// [R22] Bit clock low 10 us exits sleep and resets all internal logic.
// [R23] Internal variant: host bit clock asynchronous, up to 2 MHz.
// [R24] Data width and clock variant chosen by parameters.
`timescale 1ns/1ps
`default_nettype none
module adcw_readout #(
  parameter int DATA_W    = adcw_pkg::ADCW_DATA_W,
  parameter bit INT_OSC   = 1'b0,
  parameter int SLEEP_CYC = adcw_pkg::ADCW_SLEEP_CYC,
  parameter int WAKE_CYC  = adcw_pkg::ADCW_WAKE_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire adcw_pkg::adcw_sample_s smp_data,
  input  wire logic                   smp_valid,
  output logic                        smp_ready,
  input  wire logic                   sclk_pin,
  input  wire logic                   cs_n_pin,
  input  wire logic                   osc_pin,
  output logic                        serial_out_line_out,
  output logic                        serial_out_line_oe,
  output logic [23:0]                 conversion_output_word,
  output logic                        settled,
  output logic                        asleep
);
  import adcw_pkg::*;

  localparam int CW = $clog2(SLEEP_CYC + WAKE_CYC + 1);
  localparam logic [CW-1:0] SLEEP_LAST = CW'(SLEEP_CYC - 1);
  localparam logic [CW-1:0] WAKE_LAST  = CW'(WAKE_CYC - 1);
  localparam logic [9:0] CONV_LAST = 10'(ADCW_CONV_PERIOD - 1);
  localparam logic [9:0] LEAD_PT   = 10'(ADCW_CONV_PERIOD - 1 - ADCW_OSC_LEAD);
  localparam logic [2:0] SETTLE_N  = 3'(ADCW_SETTLE_CONV);
  localparam logic [2:0] OD_HOLD_N = 3'(ADCW_OD_HOLD);
  localparam logic [4:0] IDX_START = INT_OSC ? ADCW_IDX_INT : ADCW_IDX_EXT;

  logic [2:0]       sync_a;
  logic [2:0]       sync_b;
  logic [2:0]       sync_p;
  logic             sclk_s;
  logic             cs_s;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             osc_rise;
  logic             cs_rise;
  logic [CW-1:0]    slp_cnt;
  logic             wake;
  logic             master_edge;
  logic [9:0]       conv_cnt;
  logic             conv_end;
  logic [2:0]       settle_cnt;
  adcw_sample_s     fifo_word;
  logic             fifo_valid;
  logic             word_in;
  logic [2:0]       od_cnt;
  logic             next_od;
  logic [2:0]       next_od_cnt;
  adcw_state_e      state;
  logic [4:0]       bit_idx;
  logic [23:0]      out_word;

  // Pins cross in through two flops; edges use only the second stage onward
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      // Idle pin levels: clock low, deselected, so no false edge after reset
      sync_a <= 3'h2;
      sync_b <= 3'h2;
      sync_p <= 3'h2;
    end
    else if (ce)
    begin
      sync_a <= {sclk_pin, cs_n_pin, osc_pin};
      sync_b <= sync_a;
      sync_p <= sync_b;
    end
  end

  assign sclk_s    = sync_b[2];
  assign cs_s      = sync_b[1];
  assign sclk_rise = sync_b[2] && !sync_p[2];
  assign sclk_fall = !sync_b[2] && sync_p[2];
  assign cs_rise   = sync_b[1] && !sync_p[1];
  assign osc_rise  = sync_b[0] && !sync_p[0];

  // Sleep detector; a long high bit clock stops conversions and flushes the queued results
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      asleep  <= 1'b0;
      slp_cnt <= '0;
    end
    else if (ce)
    begin
      if (!asleep)
      begin
        if (!sclk_s)
          slp_cnt <= '0;
        else if (slp_cnt == SLEEP_LAST)
        begin
          asleep  <= 1'b1; // R21
          slp_cnt <= '0;
        end
        else
          slp_cnt <= slp_cnt + 1'b1;
      end
      else
      begin
        if (sclk_s)
          slp_cnt <= '0;
        else if (slp_cnt == WAKE_LAST)
        begin
          asleep  <= 1'b0; // R22
          slp_cnt <= '0;
        end
        else
          slp_cnt <= slp_cnt + 1'b1;
      end
    end
  end

  assign wake = asleep && !sclk_s && (slp_cnt == WAKE_LAST); // R22

  // Master clock: bit clock or internal oscillator, never while asleep
  assign master_edge = !asleep && (INT_OSC ? osc_rise : sclk_rise); // R01 R11 R24
  assign conv_end    = master_edge && (conv_cnt == CONV_LAST); // R19

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && wake))
      conv_cnt <= '0;
    else if (ce && master_edge)
      conv_cnt <= (conv_cnt == CONV_LAST) ? '0 : conv_cnt + 1'b1; // R19
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && wake))
      settle_cnt <= '0;
    else if (ce && conv_end && settle_cnt != SETTLE_N)
      settle_cnt <= settle_cnt + 1'b1; // R20
  end

  assign settled = (settle_cnt == SETTLE_N); // R20

  // Filter results queue here; a stalled queue pushes back on the filter
  adcw_fifo #(
    .WIDTH ($bits(adcw_sample_s)),
    .DEPTH (ADCW_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .flush     (asleep),
    .in_data   (smp_data),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (conv_end)
  );

  assign word_in = conv_end && fifo_valid;

  function automatic logic [23:0] build_word(input adcw_sample_s s, input logic od);
    logic signed [23:0] hi;
    logic signed [23:0] lo;
    logic               ovr;
    logic [19:0]        field;
    logic [23:0]        w;
    hi    = 24'((24'sd1 <<< (DATA_W - 1)) - 24'sd1);
    lo    = 24'(-(24'sd1 <<< (DATA_W - 1)));
    ovr   = (s.raw > hi) || (s.raw < lo); // R16
    field = '0;
    if (s.raw > hi)
      field[DATA_W-1:0] = hi[DATA_W-1:0]; // R18
    else if (s.raw < lo)
      field[DATA_W-1:0] = lo[DATA_W-1:0]; // R18
    else
      field[DATA_W-1:0] = s.raw[DATA_W-1:0]; // R18
    w = {4'h0, field}; // R15
    w[ADCW_OF_BIT] = ovr; // R14
    w[ADCW_OD_BIT] = od; // R14 R17
    return w;
  endfunction

  // Oscillation flag holds through four stable words
  always_comb
  begin
    next_od     = 1'b0;
    next_od_cnt = od_cnt;
    if (fifo_word.mod_osc)
    begin
      next_od     = 1'b1;
      next_od_cnt = OD_HOLD_N; // R17
    end
    else if (od_cnt != '0)
    begin
      next_od     = 1'b1;
      next_od_cnt = od_cnt - 1'b1; // R17
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && wake))
      od_cnt <= '0;
    else if (ce && word_in)
      od_cnt <= next_od_cnt;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && wake))
      out_word <= ADCW_WORD_RST;
    else if (ce && word_in && state != ST_SHIFT)
      out_word <= build_word(fifo_word, next_od); // R08 R13 R10
  end

  assign conversion_output_word = out_word;

  // Readout sequence
  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && wake))
    begin
      state   <= ST_IDLE;
      bit_idx <= '0;
    end
    else if (ce)
    begin
      case (state)
        ST_IDLE:
        begin
          if (word_in)
            state <= ST_READY;
        end
        ST_READY:
        begin
          if (word_in)
            state <= ST_READY; // R13 R07
          else if (INT_OSC && master_edge && conv_cnt == LEAD_PT)
            state <= ST_LATE; // R12
          else if (sclk_fall && !cs_s)
          begin
            state   <= ST_SHIFT; // R04
            bit_idx <= IDX_START; // R04 R11
          end
        end
        ST_SHIFT:
        begin
          if (cs_rise)
            state <= ST_IDLE; // R10
          else if (sclk_fall)
          begin
            if (bit_idx == '0)
              state <= ST_IDLE; // R06
            else
              bit_idx <= bit_idx - 1'b1; // R05
          end
        end
        ST_LATE:
        begin
          if (word_in)
            state <= ST_READY; // R12
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Line level from state; low while ready, high when idle or late
  always_comb
  begin
    case (state)
      ST_READY: serial_out_line_out = 1'b0; // R02 R03
      ST_SHIFT: serial_out_line_out = out_word[bit_idx]; // R05
      default:  serial_out_line_out = 1'b1; // R06 R12
    endcase
  end

  assign serial_out_line_oe = !cs_s; // R02 R07

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_hiz_deselected;
    cs_s |-> !serial_out_line_oe;
  endproperty
  a_hiz_deselected: assert property (p_hiz_deselected) // R02
    else $error("data line driven while deselected");

  property p_ready_low;
    (ce && word_in && state != ST_SHIFT && !cs_s) |=> (serial_out_line_out == 1'b0);
  endproperty
  a_ready_low: assert property (p_ready_low) // R03
    else $error("data line not low after new word");

  property p_shift_end;
    (ce && state == ST_SHIFT && sclk_fall && !cs_rise && bit_idx == 5'h00)
      |=> (state == ST_IDLE && serial_out_line_out);
  endproperty
  a_shift_end: assert property (p_shift_end) // R06
    else $error("line not high after last bit");

  property p_shift_start;
    (ce && state == ST_READY && !word_in && !(INT_OSC && conv_cnt == LEAD_PT && master_edge)
      && sclk_fall && !cs_s) |=> (state == ST_SHIFT && bit_idx == IDX_START);
  endproperty
  a_shift_start: assert property (p_shift_start) // R04
    else $error("shift did not start at lead bit");

  property p_no_update_shift;
    (ce && state == ST_SHIFT && conv_end) |=> $stable(out_word);
  endproperty
  a_no_update_shift: assert property (p_no_update_shift) // R08
    else $error("output word changed during shift");

  property p_abort;
    (ce && state == ST_SHIFT && cs_rise) |=> (state == ST_IDLE);
  endproperty
  a_abort: assert property (p_abort) // R10
    else $error("read not abandoned on deselect");

  property p_word_fmt;
    !out_word[ADCW_LEAD_BIT] && !out_word[ADCW_PAD_BIT]
      && ((out_word[ADCW_PAD_BIT-1:0] >> DATA_W) == 20'h0_0000);
  endproperty
  a_word_fmt: assert property (p_word_fmt) // R14
    else $error("fixed zero bits of word set");

  property p_rate;
    (ce && conv_end) |=> (conv_cnt == 10'h000);
  endproperty
  a_rate: assert property (p_rate) // R19
    else $error("conversion period count wrong");

  property p_late;
    (ce && INT_OSC && state == ST_READY && !word_in && master_edge && conv_cnt == LEAD_PT)
      |=> (state == ST_LATE && serial_out_line_out);
  endproperty
  a_late: assert property (p_late) // R12
    else $error("unread word did not raise line early");

  property p_unsettled;
    (ce && wake) |=> !settled;
  endproperty
  a_unsettled: assert property (p_unsettled) // R20
    else $error("settled right after wake");

  c_full_read: cover property (state == ST_SHIFT && sclk_fall && bit_idx == 5'h00 && !cs_rise);
  c_abort:     cover property (state == ST_SHIFT && cs_rise);
  c_late:      cover property (state == ST_LATE);
  c_wake:      cover property (wake);
endmodule
`default_nettype wire

// file: shared/adcw_pkg.sv
`default_nettype none
package adcw_pkg;

  // Conversion word layout
  localparam int ADCW_WORD_W   = 24;
  localparam int ADCW_FIELD_W  = 20;
  localparam int ADCW_RAW_W    = 24;
  localparam int ADCW_LEAD_BIT = 23;
  localparam int ADCW_OF_BIT   = 22;
  localparam int ADCW_OD_BIT   = 21;
  localparam int ADCW_PAD_BIT  = 20;
  localparam int ADCW_DATA_W   = 20;
  localparam logic [23:0] ADCW_WORD_RST = 24'h00_0000;

  // Shift start index: external clock repeats the lead bit once
  localparam logic [4:0] ADCW_IDX_EXT = 5'h17;
  localparam logic [4:0] ADCW_IDX_INT = 5'h16;

  // Conversion timing, in master clock periods or words
  localparam int ADCW_CONV_PERIOD = 612;
  localparam int ADCW_OSC_LEAD    = 17;
  localparam int ADCW_SETTLE_CONV = 4;
  localparam int ADCW_OD_HOLD     = 4;
  localparam int ADCW_FIFO_DEPTH  = 32;

  // Sleep entry and exit times
  localparam int ADCW_CLK_NS   = 40;
  localparam int ADCW_SLEEP_NS = 200_000;
  localparam int ADCW_WAKE_NS  = 10_000;
  localparam int ADCW_SLEEP_CYC = (ADCW_SLEEP_NS + ADCW_CLK_NS - 1) / ADCW_CLK_NS;
  localparam int ADCW_WAKE_CYC  = (ADCW_WAKE_NS + ADCW_CLK_NS - 1) / ADCW_CLK_NS;

  typedef struct packed {
    logic signed [23:0] raw;
    logic               mod_osc;
  } adcw_sample_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READY = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_LATE  = 4'b1000
  } adcw_state_e;

endpackage
`default_nettype wire

// file: rtl/adcw_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module adcw_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             wr;
  logic             rd;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];
  assign wr = in_valid && in_ready && !flush;
  assign rd = out_valid && out_ready && !flush;

  always_ff @(posedge clk)
  begin
    if (ce && wr)
    begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && flush))
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      if (wr)
      begin
        wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
      end
      if (rd)
      begin
        rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW + 1)'(wr) - (AW + 1)'(rd);
    end
  end
endmodule
`default_nettype wire

// file: tb/adcw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcw_host_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic park_high,
  input  wire logic dout,
  input  wire logic doe,
  output logic      sclk_pin,
  output logic      line
);
  logic       clk_q  = 1'b0;
  logic [1:0] ph     = 2'h0;
  int         n_rise = 0;

  assign sclk_pin = clk_q;
  // Board pull-up holds the released line high
  assign line = doe ? dout : 1'b1;

  // Free-running 320 ns master clock; parked at a level for sleep control
  always @(posedge clk)
  begin
    if (!run)
    begin
      clk_q <= park_high;
      ph    <= 2'h0;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
      begin
        clk_q <= ~clk_q;
        if (!clk_q)
          n_rise <= n_rise + 1;
      end
    end
  end

  // First fall that finds the line low opens the shift
  task automatic wait_ready(output int at_rise, output logic ok);
    int k;
    ok = 1'b0;
    for (k = 0; k < 700 && !ok; k++)
    begin
      @(negedge clk_q);
      #1;
      ok = (line === 1'b0);
    end
    at_rise = n_rise;
  endtask

  // Taken on rises, two clocks late to clear the synchroniser delay
  task automatic shift_in(input int nb, output logic [23:0] w);
    w = 24'h00_0000;
    repeat (nb)
    begin
      @(posedge clk_q);
      repeat (2) @(posedge clk);
      #1;
      w = {w[22:0], line};
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcw_pkg::*;
  localparam int SLEEP_T = 40;
  localparam int WAKE_T  = 10;

  logic         clk         = 1'b0;
  logic         nrst        = 1'b0;
  logic         cs_n        = 1'b1;
  logic         run         = 1'b0;
  logic         park        = 1'b0;
  logic         smp_valid   = 1'b0;
  adcw_sample_s smp_data    = '0;
  logic         smp_ready;
  logic         line_out;
  logic         line_oe;
  logic         settled;
  logic         asleep;
  logic         sclk;
  logic         line;
  logic [23:0]  word;
  int           miscompares = 0;
  int           compares    = 0;
  logic [23:0]  raws [13]   = '{24'h01_2345, 24'h07_FFFF, 24'h10_0000, 24'hF0_0000,
                                24'hFF_FFFF, 24'h00_0000, 24'h00_0000, 24'h00_0000,
                                24'h00_0000, 24'h00_0000, 24'hFF_F000, 24'h00_0001,
                                24'hF8_0000};
  logic [12:0]  osc         = 13'h0010;
  logic [12:0]  od          = 13'h01F0;

  always #20 clk = ~clk;

  adcw_readout #(.DATA_W(20), .INT_OSC(1'b0), .SLEEP_CYC(SLEEP_T), .WAKE_CYC(WAKE_T))
    adcw_readout_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .smp_data(smp_data),
      .smp_valid(smp_valid), .smp_ready(smp_ready), .sclk_pin(sclk), .cs_n_pin(cs_n),
      .osc_pin(1'b0), .serial_out_line_out(line_out), .serial_out_line_oe(line_oe),
      .conversion_output_word(word), .settled(settled), .asleep(asleep));

  adcw_host_model host_inst (.clk(clk), .run(run), .park_high(park), .dout(line_out),
    .doe(line_oe), .sclk_pin(sclk), .line(line));

  function automatic logic [23:0] exp_word(input logic [23:0] r, input logic d);
    logic        ovr;
    logic [19:0] v;
    ovr = ($signed(r) > $signed(24'h07_FFFF)) || ($signed(r) < $signed(24'hF8_0000));
    v   = ovr ? (r[23] ? 20'h8_0000 : 20'h7_FFFF) : r[19:0];
    return {1'b0, ovr, d, 1'b0, v};
  endfunction

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_sleep(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && asleep !== v; k++)
      @(posedge clk);
    #1;
  endtask

  task automatic read_one(input logic [23:0] exp, output int at);
    logic        ok;
    logic [23:0] w;
    host_inst.wait_ready(at, ok);
    check(ok, 1'b1);
    check(line_oe, 1'b1);
    host_inst.shift_in(24, w);
    check(w, exp);
    @(negedge sclk);
    repeat (6) @(posedge clk);
    #1;
    check(line, 1'b1);
  endtask

  initial
  begin
    int          r0;
    int          r1;
    int          i;
    logic        ok;
    logic [23:0] w;
    r0 = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 32; i++)
    begin
      smp_data.raw     <= (i < 13) ? raws[i] : 24'h00_0000;
      smp_data.mod_osc <= (i < 13) ? osc[i] : 1'b0;
      smp_valid        <= 1'b1;
      @(posedge clk);
    end
    smp_valid <= 1'b0;
    repeat (800) @(posedge clk);
    #1;
    check(smp_ready, 1'b0);
    check(word, 24'h00_0000);
    @(posedge clk);
    cs_n <= 1'b0;
    run  <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      read_one(exp_word(raws[i], od[i]), r1);
      if (i == 1)
        check(24'(r1 - r0), 24'h00_0264);
      if (i == 2)
        check(settled, 1'b0);
      if (i == 3)
        check(settled, 1'b1);
      r0 = r1;
    end
    @(posedge clk);
    cs_n <= 1'b1;
    for (i = 0; i < 6000 && word !== exp_word(raws[10], od[10]); i++)
      @(posedge clk);
    #1;
    check(word, exp_word(raws[10], od[10]));
    check(line_oe, 1'b0);
    @(posedge clk);
    cs_n <= 1'b0;
    read_one(exp_word(raws[10], od[10]), r1);
    host_inst.wait_ready(r1, ok);
    host_inst.shift_in(8, w);
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(line_oe, 1'b0);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(line, 1'b1);
    read_one(exp_word(raws[12], od[12]), r1);
    @(posedge clk);
    run  <= 1'b0;
    park <= 1'b1;
    repeat (30) @(posedge clk);
    #1;
    check(asleep, 1'b0);
    wait_sleep(1'b1, 200);
    check(asleep, 1'b1);
    check(smp_ready, 1'b1);
    @(posedge clk);
    park <= 1'b0;
    wait_sleep(1'b0, 100);
    check(asleep, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    check(word, 24'h00_0000);
    check(settled, 1'b0);
    @(posedge clk);
    smp_data.raw     <= 24'h05_4321;
    smp_data.mod_osc <= 1'b0;
    smp_valid        <= 1'b1;
    @(posedge clk);
    smp_valid <= 1'b0;
    run       <= 1'b1;
    read_one(24'h05_4321, r1);
    test_done();
  end

  // Span covers fourteen conversions with margin
  initial
  begin
    #(90_000 * 40);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
